/* rtl/csm_config_set_manager.sv */
// Local design decisions: the APB register port and the register offsets.
`timescale 1ns/1ps
// What this block does
// - working set is volatile, lost on reset
// - register writes change only working set
// - four factory setups fixed, never overwritten
// - baseline selector picks setup, survives reset
// - standard setup: low gain, autos off
// - high gain setup: standard plus 6 dB
// - auto setup: gain/exposure continuous, minimal gain
// - baseline selector delivered as auto setup
// - three non-volatile user slots survive reset
// - save copies working set into slot
// - lookup table not saved, cleared on reset
// - startup set copied into working at reset
// - running device loads baseline or slot
// - boot selector names startup set
module csm_config_set_manager
   import csm_pkg::*;
#(
   parameter int PARAM_WORDS = 4,
   parameter int LUT_WORDS = 4,
   parameter logic [31:0] GAIN_LOW = 32'h0000_0000,
   parameter logic [31:0] GAIN_6DB = 32'h0000_0040,
   parameter logic [31:0] EXPOSURE_DEF = 32'h0000_1000,
   parameter logic [31:0] COLOR_TUNE = 32'h0000_0001
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic nv_init_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic acq_active,
   output logic [31:0] gain_value,
   output logic [31:0] auto_ctrl,
   output logic [31:0] exposure_value,
   output logic [31:0] color_ctrl
);
   localparam int IW = $clog2(PARAM_WORDS);
   localparam int LW = $clog2(LUT_WORDS);
   localparam logic [IW-1:0] LAST_IDX = IW'(PARAM_WORDS - 1);
   localparam int COPY_LAST = PARAM_WORDS - 1;

   // =====================================================
   // storage
   logic [31:0] working [PARAM_WORDS];
   logic [31:0] lut [LUT_WORDS];
   logic [31:0] slots [3][PARAM_WORDS];
   logic [SEL_W-1:0] factory_baseline_select;
   logic [SEL_W-1:0] boot_set_select;
   logic [SEL_W-1:0] user_slot_select;
   logic slot_store_cmd;
   logic slot_restore_cmd;
   logic ignored;
   csm_state_t state;
   csm_state_t next_state;
   logic [IW-1:0] idx;

   function automatic logic [31:0] factory_word(input logic [1:0] fsel,
                                                input int w);
      logic [31:0] v;
      v = 32'h0000_0000;
      case (w)
         W_GAIN: v = (fsel == FAC_HIGH_GAIN) ? GAIN_LOW + GAIN_6DB
                                              : GAIN_LOW;
         W_AUTO: v = (fsel == FAC_AUTO) ? AUTO_CONT_MIN_GAIN
                                         : AUTO_OFF;
         W_EXPOSURE: v = EXPOSURE_DEF;
         W_COLOR: v = (fsel == FAC_COLOR) ? COLOR_TUNE : 32'h0000_0000;
         default: v = 32'h0000_0000;
      endcase
      return v;
   endfunction

   // =====================================================
   // apb decode
   wire logic setup = psel & ~penable;
   wire logic done = psel & penable & pready;
   wire logic wr = done & pwrite;
   wire logic idle = (state == CSM_IDLE);
   wire logic [REGION_IDX_W-1:0] ridx = paddr[WORD_LSB +: REGION_IDX_W];
   wire logic hit_work = ((paddr & REGION_MASK) == WORK_BASE)
                         && (int'(ridx) < PARAM_WORDS);
   wire logic hit_lut = ((paddr & REGION_MASK) == LUT_BASE)
                        && (int'(ridx) < LUT_WORDS);
   wire logic [IW-1:0] widx = ridx[IW-1:0];
   wire logic [LW-1:0] lidx = ridx[LW-1:0];
   wire logic hit_fac = (paddr == OFS_FACTORY_SEL);
   wire logic hit_user = (paddr == OFS_USER_SEL);
   wire logic hit_store = (paddr == OFS_STORE_CMD);
   wire logic hit_restore = (paddr == OFS_RESTORE_CMD);
   wire logic hit_boot = (paddr == OFS_BOOT_SEL);
   wire logic hit_status = (paddr == OFS_STATUS);
   wire logic mapped = hit_work | hit_lut | hit_fac | hit_user | hit_store
                       | hit_restore | hit_boot | hit_status;
   wire logic can_go = idle & ~acq_active & ~slot_store_cmd
                       & ~slot_restore_cmd;
   wire logic req_store = wr & hit_store & pwdata[0];
   wire logic req_restore = wr & hit_restore & pwdata[0];
   wire logic req_fac = wr & hit_fac;
   wire logic go_store = req_store & can_go
                         & (user_slot_select != SET_BASELINE);
   wire logic go_restore = req_restore & can_go;
   wire logic go_fac = req_fac & idle & ~acq_active;
   wire logic refused = (req_store & ~go_store)
                        | (req_restore & ~go_restore)
                        | (req_fac & ~go_fac);
   wire logic [31:0] status_word = {29'h0, ignored, acq_active, ~idle};
   logic [31:0] rd_mux;
   always_comb
   begin
      rd_mux = 32'h0000_0000;
      if (hit_work)
         rd_mux = working[widx];
      else if (hit_lut)
         rd_mux = lut[lidx];
      else if (hit_fac)
         rd_mux = {30'h0, factory_baseline_select};
      else if (hit_user)
         rd_mux = {30'h0, user_slot_select};
      else if (hit_store)
         rd_mux = {31'h0, slot_store_cmd};
      else if (hit_restore)
         rd_mux = {31'h0, slot_restore_cmd};
      else if (hit_boot)
         rd_mux = {30'h0, boot_set_select};
      else if (hit_status)
         rd_mux = status_word;
   end

   // =====================================================
   // copy engine
   wire logic [SEL_W-1:0] src_sel = (state == CSM_BOOT) ? boot_set_select
                                                        : user_slot_select;
   wire logic [1:0] slot_of_src = 2'(src_sel - SET_SLOT1);
   wire logic [1:0] slot_of_user = 2'(user_slot_select - SET_SLOT1);
   wire logic [31:0] src_word = (src_sel == SET_BASELINE)
                                ? factory_word(factory_baseline_select,
                                               int'(idx))
                                : slots[slot_of_src][idx];
   wire logic copy_last = (idx == LAST_IDX);
   wire logic into_work = (state == CSM_BOOT) | (state == CSM_LOAD);

   always_comb
   begin
      next_state = state;
      case (state)
         CSM_IDLE:
            if (slot_store_cmd)
               next_state = CSM_SAVE;
            else if (slot_restore_cmd)
               next_state = CSM_LOAD;
         CSM_BOOT, CSM_SAVE, CSM_LOAD:
            if (copy_last)
               next_state = CSM_IDLE;
         default: next_state = CSM_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state <= CSM_BOOT;
         idx <= '0;
      end
      else
      begin
         state <= next_state;
         idx <= (state == CSM_IDLE || copy_last) ? '0 : IW'(idx + 1'b1);
      end
   end

   // =====================================================
   // volatile registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
         user_slot_select <= SET_BASELINE;
         slot_store_cmd <= 1'b0;
         slot_restore_cmd <= 1'b0;
         ignored <= 1'b0;
         for (int i = 0; i < PARAM_WORDS; i++)
            working[i] <= 32'h0000_0000;
         for (int i = 0; i < LUT_WORDS; i++)
            lut[i] <= 32'h0000_0000;
      end
      else
      begin
         pready <= psel & penable & ~pready;
         if (psel & penable & ~pready)
         begin
            prdata <= pwrite ? 32'h0000_0000 : rd_mux;
            pslverr <= ~mapped;
         end
         if (wr & hit_user & idle)
            user_slot_select <= pwdata[SEL_W-1:0];
         if (go_store)
            slot_store_cmd <= 1'b1;
         else if (state == CSM_SAVE && copy_last)
            slot_store_cmd <= 1'b0;
         if (go_restore)
            slot_restore_cmd <= 1'b1;
         else if (state == CSM_LOAD && copy_last)
            slot_restore_cmd <= 1'b0;
         if (refused)
            ignored <= 1'b1;
         else if (go_store | go_restore | go_fac)
            ignored <= 1'b0;
         if (into_work)
            working[idx] <= src_word;
         else if (wr & hit_work & idle)
            working[widx] <= pwdata;
         if (wr & hit_lut & idle)
            lut[lidx] <= pwdata;
      end
   end

   // =====================================================
   // non-volatile registers
   always_ff @(posedge pclk or negedge nv_init_n)
   begin
      if (!nv_init_n)
      begin
         factory_baseline_select <= FAC_DELIVERY;
         boot_set_select <= BOOT_DELIVERY;
         for (int s = 0; s < 3; s++)
            for (int i = 0; i < PARAM_WORDS; i++)
               slots[s][i] <= 32'h0000_0000;
      end
      else
      begin
         if (go_fac)
            factory_baseline_select <= pwdata[SEL_W-1:0];
         if (wr & hit_boot & idle)
            boot_set_select <= pwdata[SEL_W-1:0];
         if (state == CSM_SAVE)
            slots[slot_of_user][idx] <= working[idx];
      end
   end

   assign gain_value = working[W_GAIN];
   assign auto_ctrl = working[W_AUTO];
   assign exposure_value = working[W_EXPOSURE];
   assign color_ctrl = working[W_COLOR];

   // =====================================================
   // assertions
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   a_save_length: assert property ((state == CSM_SAVE && idx == '0)
      |-> ##COPY_LAST (state == CSM_SAVE) ##1 (state == CSM_IDLE))
      else $error("save copy length wrong");
   a_load_word: assert property (into_work
      |=> working[$past(idx)] == $past(src_word))
      else $error("loaded word differs from source");
   a_save_word: assert property ((state == CSM_SAVE && nv_init_n)
      |=> slots[$past(slot_of_user)][$past(idx)] == $past(working[idx]))
      else $error("saved word differs from working");
   a_store_clear: assert property ((state == CSM_SAVE && copy_last)
      |=> !slot_store_cmd && state == CSM_IDLE)
      else $error("store command not cleared");
   a_acq_ignore: assert property (acq_active && idle
      && !slot_store_cmd && !slot_restore_cmd && (req_store | req_restore)
      |=> ignored && state == CSM_IDLE && !slot_store_cmd && !slot_restore_cmd)
      else $error("request during acquisition taken");
   a_baseline_hold: assert property (req_fac && acq_active
      && nv_init_n |=> $stable(factory_baseline_select))
      else $error("baseline changed while acquiring");
   a_high_gain: assert property (into_work && src_sel == SET_BASELINE
      && factory_baseline_select == FAC_HIGH_GAIN && int'(idx) == W_GAIN
      |=> gain_value == GAIN_LOW + GAIN_6DB)
      else $error("high gain offset wrong");
   a_lut_boot: assert property ((state == CSM_BOOT)
      |-> lut[0] == 32'h0000_0000)
      else $error("lookup table kept over reset");
   a_ready_wait: assert property ((setup ##1 (psel && penable))
      |-> !pready ##1 pready)
      else $error("apb answer timing wrong");

   c_save: cover property (state == CSM_SAVE ##1 state == CSM_SAVE);
   c_load_base: cover property (state == CSM_LOAD
      && user_slot_select == SET_BASELINE);
   c_load_slot: cover property (state == CSM_LOAD
      && user_slot_select == SET_SLOT3);
   c_ignored: cover property (refused);
endmodule

/* rtl/csm_pkg.sv */
package csm_pkg;
   // =====================================================
   // register offsets
   localparam logic [7:0] OFS_FACTORY_SEL = 8'h00;
   localparam logic [7:0] OFS_USER_SEL = 8'h04;
   localparam logic [7:0] OFS_STORE_CMD = 8'h08;
   localparam logic [7:0] OFS_RESTORE_CMD = 8'h0c;
   localparam logic [7:0] OFS_BOOT_SEL = 8'h10;
   localparam logic [7:0] OFS_STATUS = 8'h14;
   localparam logic [7:0] REGION_MASK = 8'he0;
   localparam logic [7:0] WORK_BASE = 8'h20;
   localparam logic [7:0] LUT_BASE = 8'h40;
   localparam int WORD_LSB = 2;
   localparam int REGION_IDX_W = 3;

   // =====================================================
   // selector codes
   localparam logic [1:0] SET_BASELINE = 2'h0;
   localparam logic [1:0] SET_SLOT1 = 2'h1;
   localparam logic [1:0] SET_SLOT3 = 2'h3;
   localparam logic [1:0] FAC_STANDARD = 2'h0;
   localparam logic [1:0] FAC_HIGH_GAIN = 2'h1;
   localparam logic [1:0] FAC_AUTO = 2'h2;
   localparam logic [1:0] FAC_COLOR = 2'h3;
   localparam logic [1:0] FAC_DELIVERY = FAC_AUTO;
   localparam logic [1:0] BOOT_DELIVERY = SET_BASELINE;

   // =====================================================
   // working set word layout
   localparam int W_GAIN = 0;
   localparam int W_AUTO = 1;
   localparam int W_EXPOSURE = 2;
   localparam int W_COLOR = 3;
   localparam int SEL_W = 2;
   localparam int ST_BUSY_BIT = 0;
   localparam int ST_ACQ_BIT = 1;
   localparam int ST_IGN_BIT = 2;
   // auto word: gain mode [1:0], exposure mode [3:2], min gain [4]
   localparam logic [31:0] AUTO_OFF = 32'h0000_0000;
   localparam logic [31:0] AUTO_CONT_MIN_GAIN = 32'h0000_001a;

   // =====================================================
   // copy engine states
   typedef enum logic [3:0] {
      CSM_IDLE = 4'b0001,
      CSM_BOOT = 4'b0010,
      CSM_SAVE = 4'b0100,
      CSM_LOAD = 4'b1000
   } csm_state_t;
endpackage

/* tb/config_set_manager_tb.sv */
`timescale 1ns/1ps
module config_set_manager_tb
   import csm_pkg::*;
;
   logic pclk, presetn, nv_init_n, psel, penable, pwrite, acq_active;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, seed, d;
   logic pready, pslverr, err;
   logic [31:0] gain_value, auto_ctrl, exposure_value, color_ctrl;
   logic [31:0] wk [4];
   logic [31:0] e [4];
   logic [31:0] slot_m [4][4];
   int n_fail, checks_done, cyc;

   assign wk[0] = gain_value;
   assign wk[1] = auto_ctrl;
   assign wk[2] = exposure_value;
   assign wk[3] = color_ctrl;

   csm_config_set_manager dut (.pclk(pclk), .presetn(presetn),
      .nv_init_n(nv_init_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .acq_active(acq_active),
      .gain_value(gain_value), .auto_ctrl(auto_ctrl),
      .exposure_value(exposure_value), .color_ctrl(color_ctrl));
   csm_host_model host (.pclk(pclk), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr));

   always #10 pclk = ~pclk;

   // ==========================================================
   // helpers
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [31:0] fac_word(input logic [1:0] f,
      input int i);
      case (i)
         W_GAIN: return (f == FAC_HIGH_GAIN) ? 32'h0000_0040 : 32'h0;
         W_AUTO: return (f == FAC_AUTO) ? AUTO_CONT_MIN_GAIN : AUTO_OFF;
         W_EXPOSURE: return 32'h0000_1000;
         default: return (f == FAC_COLOR) ? 32'h0000_0001 : 32'h0;
      endcase
   endfunction
   task automatic check(input logic [31:0] got, input logic [31:0] exp,
      input string msg);
      checks_done++;
      if (got !== exp)
      begin
         n_fail++;
         $display("CHECK FAILED %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask
   task automatic end_of_test;
      if (n_fail == 0 && checks_done > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      logic [31:0] r;
      logic x;
      host.xfer(1'b1, a, v, r, x);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] r);
      logic x;
      host.xfer(1'b0, a, 32'h0000_0000, r, x);
   endtask
   task automatic poll(input logic [7:0] a, input int b);
      logic [31:0] r;
      int n;
      r = 32'hffff_ffff;
      for (n = 0; n < 20 && r[b] !== 1'b0; n++)
         rd(a, r);
      check({31'h0, r[b]}, 32'h0, "still busy");
   endtask
   task automatic check_work(input logic [31:0] x [4]);
      for (int i = 0; i < 4; i++)
         check(wk[i], x[i], "working word");
   endtask

   always @(posedge pclk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         n_fail++;
         end_of_test();
      end
   end

   // ==========================================================
   // main sequence
   initial
   begin
      pclk = 1'b0;
      presetn = 1'b0;
      nv_init_n = 1'b0;
      acq_active = 1'b0;
      n_fail = 0;
      checks_done = 0;
      cyc = 0;
      seed = 32'hcae44374;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      nv_init_n <= 1'b1;
      poll(OFS_STATUS, ST_BUSY_BIT);
      for (int i = 0; i < 4; i++)
         e[i] = fac_word(FAC_AUTO, i);
      check_work(e);
      rd(OFS_FACTORY_SEL, d);
      check(d, {30'h0, FAC_DELIVERY}, "baseline at delivery");
      wr(OFS_USER_SEL, {30'h0, SET_BASELINE});
      for (int f = 0; f < 4; f++)
      begin
         wr(OFS_FACTORY_SEL, 32'(f));
         wr(OFS_RESTORE_CMD, 32'h1);
         poll(OFS_RESTORE_CMD, 0);
         for (int i = 0; i < 4; i++)
            e[i] = fac_word(2'(f), i);
         check_work(e);
      end
      for (int s = 1; s < 4; s++)
      begin
         for (int i = 0; i < 4; i++)
         begin
            seed = lfsr_next(seed);
            slot_m[s][i] = seed;
            wr(WORK_BASE + 8'(i * 4), seed);
            wr(LUT_BASE + 8'(i * 4), ~seed);
         end
         check_work(slot_m[s]);
         rd(LUT_BASE + 8'h0c, d);
         check(d, ~slot_m[s][3], "table word");
         wr(OFS_USER_SEL, 32'(s));
         wr(OFS_STORE_CMD, 32'h1);
         poll(OFS_STORE_CMD, 0);
      end
      wr(OFS_BOOT_SEL, 32'h2);
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      poll(OFS_STATUS, ST_BUSY_BIT);
      check_work(slot_m[2]);
      for (int i = 0; i < 4; i++)
      begin
         rd(LUT_BASE + 8'(i * 4), d);
         check(d, 32'h0, "table kept");
      end
      rd(OFS_FACTORY_SEL, d);
      check(d, {30'h0, FAC_COLOR}, "baseline lost");
      wr(OFS_USER_SEL, 32'h1);
      acq_active <= 1'b1;
      wr(OFS_RESTORE_CMD, 32'h1);
      wr(OFS_STORE_CMD, 32'h1);
      wr(OFS_FACTORY_SEL, {30'h0, FAC_STANDARD});
      rd(OFS_STATUS, d);
      check({30'h0, d[ST_IGN_BIT], d[ST_ACQ_BIT]}, 32'h3, "flag");
      rd(OFS_FACTORY_SEL, d);
      check(d, {30'h0, FAC_COLOR}, "baseline taken");
      check_work(slot_m[2]);
      acq_active <= 1'b0;
      wr(OFS_RESTORE_CMD, 32'h1);
      poll(OFS_RESTORE_CMD, 0);
      check_work(slot_m[1]);
      rd(OFS_STATUS, d);
      check({31'h0, d[ST_IGN_BIT]}, 32'h0, "flag kept");
      wr(OFS_USER_SEL, {30'h0, SET_BASELINE});
      wr(OFS_STORE_CMD, 32'h1);
      rd(OFS_STATUS, d);
      check({30'h0, d[ST_IGN_BIT], d[ST_BUSY_BIT]}, 32'h2, "store");
      wr(OFS_RESTORE_CMD, 32'h1);
      poll(OFS_RESTORE_CMD, 0);
      for (int i = 0; i < 4; i++)
         e[i] = fac_word(FAC_COLOR, i);
      check_work(e);
      host.xfer(1'b0, 8'h18, 32'h0, d, err);
      check({d[30:0], err}, 32'h1, "unmapped access");
      end_of_test();
   end
endmodule

/* tb/csm_host_model.sv */
`timescale 1ns/1ps
module csm_host_model
(
   input wire logic pclk,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [7:0] paddr,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   initial
   begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
   end

   // ==========================================================
   // one apb transfer; released address and data lines show the inverted value
   task automatic xfer(input logic wr, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] rd, output logic err);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      paddr <= ~a;
      pwdata <= ~d;
   endtask
endmodule
